// ---- logic/pcm_pkg.sv ----
// shared constants for the port charging mode sequencer
package pcm_pkg;
   localparam int NUM_PORTS = 4;
   // axi4-lite register map (byte addresses)
   localparam logic [7:0] OFS_CHARGE_CFG = 8'h00;
   localparam logic [7:0] OFS_AUTO_CFG = 8'h04;
   localparam logic [7:0] OFS_DEV_CFG3 = 8'h08;
   localparam logic [7:0] OFS_OFF_TIME = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MODE = 8'h14;
   // field positions
   localparam int BIT_AUTO_N = 1;
   localparam int BIT_HIGH_DIV = 4;
   localparam int BIT_TRY_ALL = 0;
   localparam int BIT_COMPAT_N = 1;
   // reset values and axi response codes
   localparam logic [3:0] RST_CHARGE_EN = 4'h0;
   localparam logic [7:0] RST_AUTO_CFG = 8'h10;
   localparam logic [7:0] RST_DEV_CFG3 = 8'h02;
   localparam logic [15:0] RST_OFF_CYCLES = 16'h0100;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [2:0]
   {
      MODE_NONE = 3'b000,
      MODE_CDP = 3'b001,
      MODE_DCP = 3'b010,
      MODE_DIV3 = 3'b011,
      MODE_DIV2 = 3'b100,
      MODE_DIV1 = 3'b101,
      MODE_COMPAT = 3'b110
   } pcm_mode_t;
endpackage : pcm_pkg

// ---- logic/pcm_sequencer.sv ----
// per-port charging mode sequencer with axi4-lite configuration registers
// Function
// - per-port charge enable from config or pins
// - cdp when vbus high, configured, powered
// - disabled port gives no charging indication
// - dcp fallback after divider modes
// - divider/compat only when unconnected and auto
// - active-low auto enable; off means dcp
// - high divider default; cleared gives middle without try-all
// - unconnected enabled port drives power enable
// - start highest divider, hold until pull-up
// - divider pull-up: power off, compat or dcp
// - compat pull-up: power off, go dcp
// - dcp pull-up or data-detect: back to divider
// - try-all tries every divider level
// - no try-all, no compat: level and dcp
// - compat inserted before dcp
// - compat no try-all: high, compat, dcp
// - latch straps at reset release
// - pin-only mode uses sampled straps
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module pcm_sequencer
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] port_charge_enable_pins_i,
   input wire logic auto_sequence_pin_n_i,
   input wire logic try_all_levels_pin_i,
   input wire logic power_switching_strap_n_i,
   input wire logic ganged_strap_i,
   input wire logic serial_mode_strap_n_i,
   input wire logic power_enable_polarity_strap_i,
   input wire logic config_memory_present_i,
   input wire logic upstream_vbus_high_i,
   input wire logic upstream_configured_i,
   input wire logic [3:0] host_port_power_i,
   input wire logic [3:0] dp_pullup_i,
   input wire logic [3:0] data_detect_voltage_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [3:0] port_power_enable_o,
   output logic [11:0] port_mode_o,
   output logic power_switching_n_o,
   output logic ganged_o,
   output logic power_enable_polarity_o
);
   typedef struct packed {
      logic released;
      logic [3:0] pin_en;
      logic pin_auto_n;
      logic pin_try_all;
      logic strap_pwr_n;
      logic strap_gang;
      logic strap_ser_n;
      logic strap_pol;
      logic [3:0] cfg_en;
      logic [7:0] auto_cfg;
      logic [7:0] dev_cfg3;
      logic [15:0] off_cycles;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0][2:0] mode;
      logic [3:0][15:0] off_cnt;
      logic [3:0] pwr;
      logic [3:0] dp_seen;
   } pcm_state_t;

   pcm_state_t st_reg;
   pcm_state_t st_next;

   logic pin_mode;
   logic [3:0] en_eff;
   logic auto_on;
   logic try_all;
   logic compat_on;
   logic high_div;
   logic connected;
   logic [1:0] wr_resp;

   // pin-only strapping applies when serial slave is off and no memory found
   assign pin_mode = !st_reg.strap_ser_n ? 1'b0 : !config_memory_present_i;
   assign en_eff = pin_mode ? st_reg.pin_en : st_reg.cfg_en;
   assign auto_on = pin_mode ? !st_reg.pin_auto_n
      : !st_reg.auto_cfg[pcm_pkg::BIT_AUTO_N];
   assign try_all = pin_mode ? st_reg.pin_try_all
      : st_reg.dev_cfg3[pcm_pkg::BIT_TRY_ALL];
   assign compat_on = pin_mode ? !st_reg.pin_try_all
      : !st_reg.dev_cfg3[pcm_pkg::BIT_COMPAT_N];
   assign high_div = pin_mode ? 1'b1 : st_reg.auto_cfg[pcm_pkg::BIT_HIGH_DIV];
   assign connected = upstream_vbus_high_i;

   function automatic logic [2:0] first_div(input logic all, input logic hi);
      begin
         first_div = (all || hi) ? 3'(pcm_pkg::MODE_DIV3) : 3'(pcm_pkg::MODE_DIV2);
      end
   endfunction : first_div

   // mode following a detected pull-up in any sequencing mode
   function automatic logic [2:0] next_mode(input logic [2:0] cur, input logic all,
      input logic comp, input logic hi);
      logic [2:0] after_div;
      begin
         after_div = comp ? 3'(pcm_pkg::MODE_COMPAT) : 3'(pcm_pkg::MODE_DCP);
         next_mode = 3'(pcm_pkg::MODE_DCP);
         if (cur == 3'(pcm_pkg::MODE_DIV3))
         begin
            next_mode = all ? 3'(pcm_pkg::MODE_DIV2) : after_div;
         end
         else if (cur == 3'(pcm_pkg::MODE_DIV2))
         begin
            next_mode = all ? 3'(pcm_pkg::MODE_DIV1) : after_div;
         end
         else if (cur == 3'(pcm_pkg::MODE_DIV1))
         begin
            next_mode = after_div;
         end
         else if (cur == 3'(pcm_pkg::MODE_COMPAT))
         begin
            next_mode = 3'(pcm_pkg::MODE_DCP);
         end
         else
         begin
            next_mode = first_div(all, hi);
         end
      end
   endfunction : next_mode

   always_comb
   begin
      st_next = st_reg;
      wr_resp = pcm_pkg::RESP_OKAY;
      // straps caught once, on the first clock after reset release
      st_next.released = 1'b1;
      if (!st_reg.released)
      begin
         st_next.pin_en = port_charge_enable_pins_i;
         st_next.pin_auto_n = auto_sequence_pin_n_i;
         st_next.pin_try_all = try_all_levels_pin_i;
         st_next.strap_pwr_n = power_switching_strap_n_i;
         st_next.strap_gang = ganged_strap_i;
         st_next.strap_ser_n = serial_mode_strap_n_i;
         st_next.strap_pol = power_enable_polarity_strap_i;
      end

      // axi write: address and data accepted in either order
      st_next.awready = !st_reg.aw_got && !st_reg.bvalid;
      st_next.wready = !st_reg.w_got && !st_reg.bvalid;
      if (s_axi_awvalid && st_reg.awready)
      begin
         st_next.aw_got = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
         st_next.awready = 1'b0;
      end
      if (s_axi_wvalid && st_reg.wready)
      begin
         st_next.w_got = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
         st_next.wready = 1'b0;
      end
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
      begin
         unique case (st_reg.aw_addr)
            pcm_pkg::OFS_CHARGE_CFG:
               if (st_reg.w_strb[0]) st_next.cfg_en = st_reg.w_data[3:0];
            pcm_pkg::OFS_AUTO_CFG:
               if (st_reg.w_strb[0]) st_next.auto_cfg = st_reg.w_data[7:0];
            pcm_pkg::OFS_DEV_CFG3:
               if (st_reg.w_strb[0]) st_next.dev_cfg3 = st_reg.w_data[7:0];
            pcm_pkg::OFS_OFF_TIME:
            begin
               if (st_reg.w_strb[0]) st_next.off_cycles[7:0] = st_reg.w_data[7:0];
               if (st_reg.w_strb[1]) st_next.off_cycles[15:8] = st_reg.w_data[15:8];
            end
            pcm_pkg::OFS_STATUS, pcm_pkg::OFS_MODE: wr_resp = pcm_pkg::RESP_OKAY;
            default: wr_resp = pcm_pkg::RESP_SLVERR;
         endcase
         st_next.bvalid = 1'b1;
         st_next.bresp = wr_resp;
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
      end
      if (st_reg.bvalid && s_axi_bready)
      begin
         st_next.bvalid = 1'b0;
      end

      // axi read
      st_next.arready = !st_reg.rvalid && !st_reg.arready;
      if (s_axi_arvalid && st_reg.arready)
      begin
         st_next.arready = 1'b0;
         st_next.rvalid = 1'b1;
         st_next.rresp = pcm_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            pcm_pkg::OFS_CHARGE_CFG: st_next.rdata = {28'h0, st_reg.cfg_en};
            pcm_pkg::OFS_AUTO_CFG: st_next.rdata = {24'h0, st_reg.auto_cfg};
            pcm_pkg::OFS_DEV_CFG3: st_next.rdata = {24'h0, st_reg.dev_cfg3};
            pcm_pkg::OFS_OFF_TIME: st_next.rdata = {16'h0, st_reg.off_cycles};
            pcm_pkg::OFS_STATUS: st_next.rdata = {20'h0, pin_mode, st_reg.strap_pol,
               st_reg.strap_ser_n, st_reg.strap_gang, st_reg.strap_pwr_n,
               st_reg.pin_try_all, st_reg.pin_auto_n, connected, st_reg.pwr};
            pcm_pkg::OFS_MODE: st_next.rdata = {20'h0, st_reg.mode};
            default:
            begin
               st_next.rdata = 32'h0;
               st_next.rresp = pcm_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st_reg.rvalid && s_axi_rready)
      begin
         st_next.rvalid = 1'b0;
      end

      // per-port charging sequencer
      for (int p = 0; p < pcm_pkg::NUM_PORTS; p++)
      begin
         st_next.dp_seen[p] = dp_pullup_i[p] || data_detect_voltage_i[p];
         if (!en_eff[p])
         begin
            st_next.mode[p] = 3'(pcm_pkg::MODE_NONE);
            st_next.pwr[p] = host_port_power_i[p];
            st_next.off_cnt[p] = 16'h0;
         end
         else if (connected)
         begin
            // leaving the unconnected sequence abandons any off step
            st_next.off_cnt[p] = 16'h0;
            st_next.pwr[p] = host_port_power_i[p];
            st_next.mode[p] = (upstream_configured_i && host_port_power_i[p])
               ? 3'(pcm_pkg::MODE_CDP) : 3'(pcm_pkg::MODE_NONE);
         end
         else if (!auto_on)
         begin
            st_next.mode[p] = 3'(pcm_pkg::MODE_DCP);
            st_next.pwr[p] = 1'b1;
            st_next.off_cnt[p] = 16'h0;
         end
         else if (st_reg.off_cnt[p] != 16'h0)
         begin
            st_next.off_cnt[p] = st_reg.off_cnt[p] - 16'h1;
            st_next.pwr[p] = (st_reg.off_cnt[p] == 16'h1);
         end
         else if (st_reg.mode[p] == 3'(pcm_pkg::MODE_NONE)
            || st_reg.mode[p] == 3'(pcm_pkg::MODE_CDP))
         begin
            st_next.mode[p] = first_div(try_all, high_div);
            st_next.pwr[p] = 1'b1;
         end
         else if ((st_reg.mode[p] == 3'(pcm_pkg::MODE_DCP)) ? st_reg.dp_seen[p]
            : dp_pullup_i[p])
         begin
            // sequence step: new mode set at once while power drops for the programmed time
            st_next.mode[p] = next_mode(st_reg.mode[p], try_all, compat_on,
               high_div);
            st_next.pwr[p] = 1'b0;
            st_next.off_cnt[p] = (st_reg.off_cycles == 16'h0) ? 16'h1 : st_reg.off_cycles;
         end
         else
         begin
            st_next.pwr[p] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st_reg <= '0;
         st_reg.cfg_en <= pcm_pkg::RST_CHARGE_EN;
         st_reg.auto_cfg <= pcm_pkg::RST_AUTO_CFG;
         st_reg.dev_cfg3 <= pcm_pkg::RST_DEV_CFG3;
         st_reg.off_cycles <= pcm_pkg::RST_OFF_CYCLES;
         st_reg.strap_pwr_n <= 1'b1;
         st_reg.strap_ser_n <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign port_power_enable_o = st_reg.pwr;
   assign port_mode_o = st_reg.mode;
   assign power_switching_n_o = st_reg.strap_pwr_n;
   assign ganged_o = st_reg.strap_gang;
   assign power_enable_polarity_o = st_reg.strap_pol;

   chk_disabled_no_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !en_eff[0] |=> st_reg.mode[0] == 3'(pcm_pkg::MODE_NONE))
      else $error("disabled port shows a charging mode");
   chk_cdp_when_up: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && connected && upstream_configured_i && host_port_power_i[0]
      |=> st_reg.mode[0] == 3'(pcm_pkg::MODE_CDP))
      else $error("cdp not selected");
   chk_no_auto_dcp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && !connected && !auto_on
      |=> st_reg.mode[0] == 3'(pcm_pkg::MODE_DCP) && st_reg.pwr[0])
      else $error("dcp not used with auto off");
   chk_connect_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      connected |=> st_reg.off_cnt[0] == 16'h0 && st_reg.mode[0] != 3'(pcm_pkg::MODE_DIV3))
      else $error("sequence not stopped on connect");
   chk_off_step_power: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && !connected && auto_on && st_reg.off_cnt[0] > 16'h1
      && $stable(en_eff) && $stable(connected) && $stable(auto_on) |=> !st_reg.pwr[0])
      else $error("power back on during off step");
   chk_div_to_compat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && !connected && auto_on && !try_all && compat_on
      && st_reg.off_cnt[0] == 16'h0 && st_reg.mode[0] == 3'(pcm_pkg::MODE_DIV3)
      && dp_pullup_i[0] |=> st_reg.mode[0] == 3'(pcm_pkg::MODE_COMPAT) && !st_reg.pwr[0])
      else $error("divider pull-up did not go to compat");
   chk_compat_to_dcp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && !connected && auto_on && st_reg.off_cnt[0] == 16'h0
      && st_reg.mode[0] == 3'(pcm_pkg::MODE_COMPAT) && dp_pullup_i[0]
      |=> st_reg.mode[0] == 3'(pcm_pkg::MODE_DCP))
      else $error("compat pull-up did not go to dcp");
   chk_try_all_order: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && !connected && auto_on && try_all && st_reg.off_cnt[0] == 16'h0
      && st_reg.mode[0] == 3'(pcm_pkg::MODE_DIV3) && dp_pullup_i[0]
      |=> st_reg.mode[0] == 3'(pcm_pkg::MODE_DIV2))
      else $error("try-all skipped middle level");
   chk_dcp_back_div: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && !connected && auto_on && st_reg.off_cnt[0] == 16'h0
      && st_reg.mode[0] == 3'(pcm_pkg::MODE_DCP) && st_reg.dp_seen[0]
      |=> !st_reg.pwr[0] && st_reg.mode[0] != 3'(pcm_pkg::MODE_DCP))
      else $error("dcp detect did not restart divider");
   chk_start_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && !connected && auto_on && high_div && st_reg.off_cnt[0] == 16'h0
      && st_reg.mode[0] == 3'(pcm_pkg::MODE_NONE)
      |=> st_reg.mode[0] == 3'(pcm_pkg::MODE_DIV3) && st_reg.pwr[0])
      else $error("sequence did not start at highest level");
   chk_start_middle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_eff[0] && !connected && auto_on && !try_all && !high_div
      && st_reg.off_cnt[0] == 16'h0 && st_reg.mode[0] == 3'(pcm_pkg::MODE_NONE)
      |=> st_reg.mode[0] == 3'(pcm_pkg::MODE_DIV2))
      else $error("sequence did not start at middle level");
   chk_bvalid_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
endmodule : pcm_sequencer

// ---- testbench/pcm_device_model.sv ----
// behavioural portable device that refuses chosen charging signatures
`timescale 1ns/1ps
module pcm_device_model
(
   input wire logic clk_i,
   input wire logic [3:0] port_power_enable_i,
   input wire logic [11:0] port_mode_i,
   input wire logic [7:0] reject_mask_i,
   input wire logic [7:0] delay_i,
   output logic [3:0] dp_pullup_o,
   output logic [3:0] data_detect_voltage_o
);
   logic [7:0] age [4] = '{default: 8'h00};
   initial
   begin
      dp_pullup_o = 4'h0;
      data_detect_voltage_o = 4'h0;
   end
   // an unpowered device presents nothing, so both detect lines drop with power
   always @(posedge clk_i)
   begin
      for (int p = 0; p < 4; p++)
      begin
         if (!port_power_enable_i[p])
         begin
            age[p] <= 8'h00;
            dp_pullup_o[p] <= 1'b0;
            data_detect_voltage_o[p] <= 1'b0;
         end
         else if (age[p] < delay_i)
            age[p] <= age[p] + 8'h01;
         else if (reject_mask_i[port_mode_i[p*3 +: 3]])
         begin
            // a dedicated port is refused through data-detect, the others by pull-up
            dp_pullup_o[p] <= (port_mode_i[p*3 +: 3] != 3'h2);
            data_detect_voltage_o[p] <= (port_mode_i[p*3 +: 3] == 3'h2);
         end
      end
   end
endmodule : pcm_device_model

// ---- testbench/port_charging_mode_sequencer_tb_top.sv ----
// self-checking bench for the port charging mode sequencer
`timescale 1ns/1ps
module port_charging_mode_sequencer_tb_top;
   logic clk_i, rst_n_i, auto_sequence_pin_n_i, try_all_levels_pin_i;
   logic power_switching_strap_n_i, ganged_strap_i, serial_mode_strap_n_i;
   logic power_enable_polarity_strap_i, config_memory_present_i;
   logic upstream_vbus_high_i, upstream_configured_i;
   logic [3:0] port_charge_enable_pins_i, host_port_power_i, dp_pullup_i, data_detect_voltage_i;
   logic [7:0] s_axi_awaddr, s_axi_araddr, mask, dly;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, port_power_enable_o;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [11:0] port_mode_o;
   logic power_switching_n_o, ganged_o, power_enable_polarity_o;
   int num_errors = 0;
   int samples_checked = 0;
   pcm_sequencer i_dut
   (
      .clk_i, .rst_n_i, .port_charge_enable_pins_i, .auto_sequence_pin_n_i,
      .try_all_levels_pin_i, .power_switching_strap_n_i, .ganged_strap_i,
      .serial_mode_strap_n_i, .power_enable_polarity_strap_i, .config_memory_present_i,
      .upstream_vbus_high_i, .upstream_configured_i, .host_port_power_i, .dp_pullup_i,
      .data_detect_voltage_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .port_power_enable_o, .port_mode_o,
      .power_switching_n_o, .ganged_o, .power_enable_polarity_o
   );
   pcm_device_model i_dev
   (
      .clk_i, .port_power_enable_i(port_power_enable_o), .port_mode_i(port_mode_o),
      .reject_mask_i(mask), .delay_i(dly), .dp_pullup_o(dp_pullup_i),
      .data_detect_voltage_o(data_detect_voltage_i)
   );
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, er);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, exp);
      check(s_axi_rresp, er);
   endtask : axi_rd
   // port 0 is the observed port; a disable first so every run starts from a clean sequence
   task automatic setup(input logic [3:0] en, input logic [7:0] auto, input logic [7:0] cfg3);
      axi_wr(pcm_pkg::OFS_CHARGE_CFG, 32'h0, 2'h0);
      axi_wr(pcm_pkg::OFS_AUTO_CFG, {24'h0, auto}, 2'h0);
      axi_wr(pcm_pkg::OFS_DEV_CFG3, {24'h0, cfg3}, 2'h0);
      axi_wr(pcm_pkg::OFS_CHARGE_CFG, {28'h0, en}, 2'h0);
   endtask : setup
   task automatic wait_pwr(input logic lvl, output int k);
      k = 0;
      while (port_power_enable_o[0] !== lvl && k < 2000)
      begin
         @(posedge clk_i);
         k++;
      end
      // an expired wait is a failure, not a silent return
      if (k >= 2000)
         check(port_power_enable_o[0], lvl);
   endtask : wait_pwr
   // e holds the expected modes, first one in the low bits
   task automatic seq_check(input logic [14:0] e, input int n, input int off);
      int k;
      wait_pwr(1'b1, k);
      check(port_mode_o[2:0], e[2:0]);
      for (int i = 1; i < n; i++)
      begin
         wait_pwr(1'b0, k);
         wait_pwr(1'b1, k);
         check(k, off);
         check(port_mode_o[2:0], e[i*3 +: 3]);
      end
   endtask : seq_check
   task automatic test_regs();
      check(port_mode_o, 12'h000);
      axi_rd(pcm_pkg::OFS_CHARGE_CFG, 32'h0, 2'h0);
      axi_rd(pcm_pkg::OFS_AUTO_CFG, 32'h10, 2'h0);
      axi_rd(pcm_pkg::OFS_DEV_CFG3, 32'h2, 2'h0);
      axi_rd(pcm_pkg::OFS_OFF_TIME, 32'h100, 2'h0);
      axi_wr(pcm_pkg::OFS_MODE, 32'h555, 2'h0);
      axi_rd(pcm_pkg::OFS_MODE, 32'h0, 2'h0);
      axi_wr(8'h40, 32'h1, 2'h2);
      axi_rd(8'h40, 32'h0, 2'h2);
      axi_wr(pcm_pkg::OFS_OFF_TIME, 32'h4, 2'h0);
   endtask : test_regs
   task automatic test_ports();
      mask <= 8'h00;
      setup(4'h5, 8'h10, 8'h02);
      repeat (60) @(posedge clk_i);
      check(port_mode_o, {3'h0, 3'h3, 3'h0, 3'h3});
      check(port_power_enable_o, 4'h5);
      mask <= 8'hff;
      seq_check({3'h3, 3'h2, 3'h3}, 3, 4);
   endtask : test_ports
   task automatic test_orders();
      setup(4'h1, 8'h00, 8'h02);
      seq_check({3'h4, 3'h2, 3'h4}, 3, 4);
      setup(4'h1, 8'h10, 8'h03);
      seq_check({3'h3, 3'h2, 3'h5, 3'h4, 3'h3}, 5, 4);
      dly <= 8'h28;
      setup(4'h1, 8'h10, 8'h01);
      seq_check({3'h2, 3'h6, 3'h5, 3'h4, 3'h3}, 5, 4);
      dly <= 8'h06;
      setup(4'h1, 8'h10, 8'h00);
      seq_check({3'h3, 3'h2, 3'h6, 3'h3}, 4, 4);
      setup(4'h1, 8'h00, 8'h00);
      seq_check({3'h2, 3'h6, 3'h4}, 3, 4);
   endtask : test_orders
   task automatic test_auto_off();
      mask <= 8'h00;
      setup(4'h1, 8'h12, 8'h02);
      repeat (20) @(posedge clk_i);
      check(port_mode_o, 12'h002);
      check(port_power_enable_o, 4'h1);
   endtask : test_auto_off
   task automatic test_upstream();
      setup(4'h1, 8'h10, 8'h02);
      repeat (10) @(posedge clk_i);
      upstream_vbus_high_i <= 1'b1;
      upstream_configured_i <= 1'b1;
      host_port_power_i <= 4'hf;
      repeat (10) @(posedge clk_i);
      check(port_mode_o, 12'h001);
      host_port_power_i <= 4'h0;
      repeat (10) @(posedge clk_i);
      check(port_mode_o, 12'h000);
      upstream_vbus_high_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      seq_check(15'h3, 1, 0);
   endtask : test_upstream
   // straps flip after release to prove that only the release edge counts
   task automatic test_pin_mode();
      rst_n_i <= 1'b0;
      {port_charge_enable_pins_i, try_all_levels_pin_i, config_memory_present_i} <= 6'h06;
      {power_switching_strap_n_i, ganged_strap_i, power_enable_polarity_strap_i} <= 3'h7;
      serial_mode_strap_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      mask <= 8'h00;
      port_charge_enable_pins_i <= 4'hf;
      {power_switching_strap_n_i, ganged_strap_i, power_enable_polarity_strap_i} <= 3'h0;
      repeat (20) @(posedge clk_i);
      check({power_switching_n_o, ganged_o, power_enable_polarity_o}, 3'h7);
      check(port_mode_o, 12'h003);
      mask <= 8'hff;
      seq_check({3'h2, 3'h5, 3'h4, 3'h3}, 4, 256);
   endtask : test_pin_mode
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (40000) @(posedge clk_i);
      num_errors++;
      finish_test();
   end
   initial
   begin
      {rst_n_i, port_charge_enable_pins_i, auto_sequence_pin_n_i, try_all_levels_pin_i} = '0;
      {power_switching_strap_n_i, ganged_strap_i, serial_mode_strap_n_i} = '0;
      {power_enable_polarity_strap_i, upstream_vbus_high_i, upstream_configured_i} = '0;
      config_memory_present_i = 1'b1;
      host_port_power_i = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      mask = 8'h00;
      dly = 8'h06;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      test_regs();
      test_ports();
      test_orders();
      test_auto_off();
      test_upstream();
      test_pin_mode();
      finish_test();
   end
endmodule : port_charging_mode_sequencer_tb_top
